// >>> logic/pmw_pkg.sv
// Purpose: constants for the power mode and wake-up controller
// Assumes: single 100 MHz clock domain
// Notes: slow divider code n gives a ratio of 2^(n+1), 2 up to 64
package pmw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned RESTART_CYCLES = 1024;
  localparam int unsigned SLOW_DIV_W = 3;
  localparam logic [2:0] SLOW_DIV_MAX = 3'h5;
  localparam logic [2:0] SLOW_DIV_RST = 3'h0;
  localparam int unsigned PORTA_W = 8;
  localparam logic PWDN_FLAG_RST = 1'b0;
  localparam logic TOF_RST = 1'b0;
  typedef enum logic [1:0] {
    PMW_MODE_NORMAL,
    PMW_MODE_SLOW,
    PMW_MODE_IDLE,
    PMW_MODE_SLEEP
  } pmw_mode_t;
endpackage

// >>> logic/pmw_slow_div.sv
// Purpose: divides the main clock into the slow clock enable
// Assumes: ratio code already limited by the caller
// Notes: emits a one-cycle tick every 2^(code+1) clocks
`timescale 1ns/1ns
`default_nettype none
module pmw_slow_div #(
  parameter int unsigned CNT_W = 6
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Control
  input wire logic i_run,
  input wire logic [2:0] i_ratio,
  // Tick
  output logic o_tick
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mask;

  // Width check; a narrower counter could not reach the 64 ratio
  if (CNT_W < 6) begin : g_bad_width
    $error("pmw_slow_div: counter too narrow");
  end

  // Terminal count mask from the ratio code
  assign mask = CNT_W'((7'h02 << i_ratio) - 7'h01);

  // Free counter, held clear when stopped so restart is clean
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= ((cnt_q & mask) == mask);
      cnt_q <= ((cnt_q & mask) == mask) ? '0 : cnt_q + CNT_W'(1);
    end
  end
endmodule // pmw_slow_div
`default_nettype wire

// >>> logic/pmw_ctrl.sv
// Purpose: operating mode, power-down entry, wake-up and restart control
// Assumes: core strobes are on i_mclk; pins and wake events are asynchronous
// Notes: clock gates are enables for the clock tree, not clocks themselves
// Overview of operation
// - Mode comes from speed select, idle select and stop execution
// - Normal runs main clock and CPU; idle keeps sub; sleep stops more
// - Slow mode divides main by 2 to 64; software keeps it above 100kHz
// - LCD clock follows its enable bit in normal, slow and idle
// - Watchdog clock follows option and control register; in power down only when sourced from sub
// - Only the stop instruction enters power down
// - Power down stops oscillator and halts; state is kept
// - Power down clears watchdog; it runs only on its own oscillator
// - Stop sets power-down flag and clears time-out flag
// - Wake on reset pin, Port A falling edge, interrupt, watchdog overflow
// - Reset pin wake is full reset; watchdog wake is watchdog reset
// - Power-down flag cleared by power-up or clear instruction, set by stop
// - Watchdog wake sets time-out flag and resets only PC and SP
// - Each Port A pin enables its own falling-edge wake; resume after stop
// - Disabled interrupt or full stack resumes after stop; stays pending
// - Enabled interrupt with stack room takes normal interrupt response
// - An interrupt requested two or more cycles before stop cannot wake
// - Every wake waits 1024 system clocks before resuming
// - Interrupt service entry comes at least one cycle after the delay
// - Resume-after-stop executes right when the delay ends
// - Speed select picks main or divided slow clock, ratio by divider bits
`timescale 1ns/1ns
`default_nettype none
module pmw_ctrl #(
  parameter int unsigned PORTA_W = pmw_pkg::PORTA_W,
  parameter int unsigned RESTART_CYCLES = pmw_pkg::RESTART_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Clock mode register fields
  input wire logic i_clock_speed_select,
  input wire logic i_idle_select,
  input wire logic [2:0] i_slow_clock_divider,
  input wire logic i_lcd_clock_enable,
  // Watchdog configuration and events
  input wire logic i_wdt_option_en,
  input wire logic i_wdt_ctrl_en,
  input wire logic i_wdt_src_sub,
  input wire logic i_wdt_overflow,
  // Core strobes
  input wire logic i_stop_exec,
  input wire logic i_watchdog_clear_instruction,
  // Wake sources
  input wire logic i_ext_reset_n,
  input wire logic [PORTA_W-1:0] i_porta,
  input wire logic [PORTA_W-1:0] i_porta_wake_en,
  input wire logic i_int_req,
  input wire logic i_int_enabled,
  input wire logic i_stack_full,
  // Clock gates
  output logic o_main_clk_en,
  output logic o_slow_clk_en,
  output logic o_sys_tick,
  output logic o_sub_clk_en,
  output logic o_int_clk_en,
  output logic o_lcd_clk_en,
  output logic o_wdt_clk_en,
  // Core control
  output logic o_cpu_run,
  output logic o_wdt_clear,
  output logic o_full_reset,
  output logic o_wdt_reset,
  output logic o_resume_next,
  output logic o_int_service,
  // Status
  output logic [1:0] o_mode,
  output logic o_powerdown_flag,
  output logic o_timeout_flag
);
  typedef enum logic [2:0] {
    PMW_RUN,
    PMW_DOWN,
    PMW_RESTART,
    PMW_INT_GAP
  } pmw_state_t;

  typedef enum logic [1:0] {
    PMW_WK_NEXT,
    PMW_WK_INT,
    PMW_WK_WDT
  } pmw_wake_t;

  // Restart counter just wide enough; its last value fits below 2^CNT_W
  localparam int unsigned CNT_W = $clog2(RESTART_CYCLES);
  // Divider counter spans the largest ratio of 64
  localparam int unsigned SLOW_CNT_W = 6;

  // Parameter sanity; a restart below two cycles would leave no count at all
  if (RESTART_CYCLES < 2 || PORTA_W < 1) begin : g_bad_params
    $error("pmw_ctrl: unsupported parameter values");
  end

  pmw_state_t state_q;
  pmw_wake_t wake_q;
  logic sleep_q;
  logic [CNT_W-1:0] cnt_q;
  logic rst_s1_q, rst_s2_q, rst_prev_q;
  logic [PORTA_W-1:0] pa_s1_q, pa_s2_q, pa_prev_q;
  logic int_s1_q, int_s2_q, int_prev_q;
  logic wdo_s1_q, wdo_s2_q;
  logic int_armed_q;
  logic [2:0] ratio;
  logic slow_run;
  logic slow_tick;
  logic pa_fall;
  logic int_wake;
  logic wdt_wake;
  logic rst_wake;
  logic any_wake;
  logic in_down;

  // Two-stage synchronisers for pins and asynchronous event lines
  // Reset values are the idle levels, so release never looks like an edge
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
      rst_prev_q <= 1'b1;
      pa_s1_q <= '1;
      pa_s2_q <= '1;
      pa_prev_q <= '1;
      int_s1_q <= 1'b0;
      int_s2_q <= 1'b0;
      int_prev_q <= 1'b0;
      wdo_s1_q <= 1'b0;
      wdo_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= i_ext_reset_n;
      rst_s2_q <= rst_s1_q;
      rst_prev_q <= rst_s2_q;
      pa_s1_q <= i_porta;
      pa_s2_q <= pa_s1_q;
      pa_prev_q <= pa_s2_q;
      int_s1_q <= i_int_req;
      int_s2_q <= int_s1_q;
      int_prev_q <= int_s2_q;
      wdo_s1_q <= i_wdt_overflow;
      wdo_s2_q <= wdo_s1_q;
    end
  end

  // Wake qualification; only meaningful while powered down
  // Edges come from the second stage against its delayed copy, one cycle wide
  assign in_down = (state_q == PMW_DOWN);
  assign pa_fall = |(pa_prev_q & ~pa_s2_q & i_porta_wake_en);
  assign int_wake = int_armed_q && int_s2_q && !int_prev_q;
  assign wdt_wake = wdo_s2_q;
  assign rst_wake = rst_prev_q && !rst_s2_q;
  assign any_wake = in_down && (rst_wake || pa_fall || int_wake || wdt_wake);

  // Interrupt wake armed at stop only if no request was already up
  // The request is seen two cycles late; one raised just before stop still wakes
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_armed_q <= 1'b0;
    end else if (i_stop_exec && state_q == PMW_RUN) begin
      int_armed_q <= !int_s2_q;
    end else if (!in_down) begin
      int_armed_q <= 1'b0;
    end
  end

  // Power-down sequencer; stop instruction is the only way in
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= PMW_RUN;
      wake_q <= PMW_WK_NEXT;
      sleep_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      case (state_q)
        PMW_RUN: begin
          if (i_stop_exec) begin
            state_q <= PMW_DOWN;
            sleep_q <= !i_idle_select;
          end
        end
        PMW_DOWN: begin
          if (any_wake) begin
            state_q <= PMW_RESTART;
            cnt_q <= '0;
            // Watchdog takes priority so its reset is never lost
            // An interrupt is serviced only when it woke the device alone
            if (wdt_wake) begin
              wake_q <= PMW_WK_WDT;
            end else if (int_wake && !pa_fall && !rst_wake && i_int_enabled && !i_stack_full) begin
              wake_q <= PMW_WK_INT;
            end else begin
              wake_q <= PMW_WK_NEXT;
            end
          end
        end
        PMW_RESTART: begin
          // Counts system clocks; the slow tick paces slow mode
          if (o_sys_tick) begin
            if (cnt_q == CNT_W'(RESTART_CYCLES - 1)) begin
              state_q <= (wake_q == PMW_WK_INT) ? PMW_INT_GAP : PMW_RUN;
              sleep_q <= 1'b0;
            end
            cnt_q <= cnt_q + CNT_W'(1);
          end
        end
        PMW_INT_GAP: begin
          if (o_sys_tick) begin
            state_q <= PMW_RUN;
          end
        end
        default: state_q <= PMW_RUN;
      endcase
    end
  end

  // Slow clock divider; ratio code clipped to the 64 limit
  assign ratio = (i_slow_clock_divider > pmw_pkg::SLOW_DIV_MAX) ?
                 pmw_pkg::SLOW_DIV_MAX : i_slow_clock_divider;
  // Divider runs only while the main clock does and slow mode is chosen
  assign slow_run = o_main_clk_en && !i_clock_speed_select;

  pmw_slow_div #(
    .CNT_W(SLOW_CNT_W)
  ) u_slow_div (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_run(slow_run),
    .i_ratio(ratio),
    .o_tick(slow_tick)
  );

  // Clock gating per mode; restart runs the oscillator again
  always_comb begin
    o_main_clk_en = !in_down;
    o_slow_clk_en = o_main_clk_en;
    o_sys_tick = o_main_clk_en && (i_clock_speed_select || slow_tick);
    // Sub clock is never gated; it keeps time across power down
    o_sub_clk_en = 1'b1;
    o_int_clk_en = !(in_down && sleep_q) && (i_wdt_src_sub || !in_down);
    o_lcd_clk_en = i_lcd_clock_enable && !(in_down && sleep_q);
    o_wdt_clk_en = i_wdt_option_en && i_wdt_ctrl_en && (i_wdt_src_sub || !in_down);
    o_cpu_run = (state_q == PMW_RUN);
  end

  // Mode report; speed select gives normal or slow while running
  always_comb begin
    if (in_down) begin
      o_mode = sleep_q ? pmw_pkg::PMW_MODE_SLEEP : pmw_pkg::PMW_MODE_IDLE;
    end else if (i_clock_speed_select) begin
      o_mode = pmw_pkg::PMW_MODE_NORMAL;
    end else begin
      o_mode = pmw_pkg::PMW_MODE_SLOW;
    end
  end

  // Registered pulses toward the core
  // Each pulse lasts one cycle; the core latches what it needs
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wdt_clear <= 1'b0;
      o_full_reset <= 1'b0;
      o_wdt_reset <= 1'b0;
      o_resume_next <= 1'b0;
      o_int_service <= 1'b0;
    end else begin
      o_wdt_clear <= state_q == PMW_RUN && i_stop_exec;
      // Pin reset wake asks the core for its full reset at once
      o_full_reset <= rst_wake && in_down;
      o_wdt_reset <= state_q == PMW_RESTART && o_sys_tick && wake_q == PMW_WK_WDT &&
                     cnt_q == CNT_W'(RESTART_CYCLES - 1);
      o_resume_next <= state_q == PMW_RESTART && o_sys_tick && wake_q == PMW_WK_NEXT &&
                       cnt_q == CNT_W'(RESTART_CYCLES - 1);
      o_int_service <= state_q == PMW_INT_GAP && o_sys_tick;
    end
  end

  // Power-down flag: stop sets it, clear instruction clears it
  // Power-up clears it through the reset value
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_powerdown_flag <= pmw_pkg::PWDN_FLAG_RST;
    end else if (i_stop_exec && state_q == PMW_RUN) begin
      o_powerdown_flag <= 1'b1;
    end else if (i_watchdog_clear_instruction) begin
      o_powerdown_flag <= 1'b0;
    end
  end

  // Time-out flag: set by watchdog wake, cleared by stop; set wins
  // The two never meet: one needs power down, the other needs run
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_timeout_flag <= pmw_pkg::TOF_RST;
    end else if (in_down && wdt_wake) begin
      o_timeout_flag <= 1'b1;
    end else if (i_stop_exec && state_q == PMW_RUN) begin
      o_timeout_flag <= 1'b0;
    end
  end
endmodule // pmw_ctrl
`default_nettype wire

// >>> verif/pmw_ctrl_chk.sv
// Purpose: port checker for the power mode controller
// Assumes: one clock domain, reset active low
// Notes: restart length follows the bound parameter
`timescale 1ns/1ns
`default_nettype none
module pmw_ctrl_chk #(
  parameter int unsigned RESTART_CYCLES = 1024
) (
  // Clock, reset and inputs
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_stop_exec,
  input wire logic i_watchdog_clear_instruction,
  input wire logic i_lcd_clock_enable,
  input wire logic i_wdt_option_en,
  input wire logic i_wdt_ctrl_en,
  // Watched outputs
  input wire logic o_main_clk_en,
  input wire logic o_sys_tick,
  input wire logic o_int_clk_en,
  input wire logic o_lcd_clk_en,
  input wire logic o_wdt_clk_en,
  input wire logic o_cpu_run,
  input wire logic o_wdt_clear,
  input wire logic o_wdt_reset,
  input wire logic o_resume_next,
  input wire logic o_int_service,
  input wire logic [1:0] o_mode,
  input wire logic o_powerdown_flag,
  input wire logic o_timeout_flag
);
  logic [31:0] cnt_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Ticks since wake; cleared while running so each wake starts from zero
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 32'h0;
    end else if (o_cpu_run) begin
      cnt_q <= 32'h0;
    end else if (o_main_clk_en && o_sys_tick) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  a_stop_halts: assert property (
    i_stop_exec && o_cpu_run |=> !o_cpu_run && !o_main_clk_en)
    else $error("stop did not halt");
  a_stop_flags: assert property (
    i_stop_exec && o_cpu_run |=> o_powerdown_flag && !o_timeout_flag)
    else $error("flags wrong after stop");
  a_stop_wdt_clr: assert property (i_stop_exec && o_cpu_run |=> o_wdt_clear)
    else $error("watchdog not cleared at stop");
  a_pwdn_cause: assert property ($rose(o_powerdown_flag) |-> $past(i_stop_exec))
    else $error("power-down flag set without stop");
  a_clr_pwdn: assert property (
    i_watchdog_clear_instruction && !i_stop_exec |=> !o_powerdown_flag)
    else $error("clear did not drop power-down flag");
  a_sleep_gates: assert property (o_mode == 2'h3 |-> !o_lcd_clk_en && !o_int_clk_en)
    else $error("sleep left a clock running");
  a_lcd_follow: assert property (o_mode != 2'h3 |-> o_lcd_clk_en == i_lcd_clock_enable)
    else $error("lcd clock ignores its enable");
  a_wdt_off: assert property (!(i_wdt_option_en && i_wdt_ctrl_en) |-> !o_wdt_clk_en)
    else $error("watchdog clock on while disabled");
  a_restart_len: assert property (
    o_resume_next |-> o_cpu_run && cnt_q == RESTART_CYCLES)
    else $error("resume not at end of restart delay");
  a_run_mode: assert property (o_cpu_run |-> !o_mode[1])
    else $error("running core reports a power-down mode");
  a_wdt_to_flag: assert property (o_wdt_reset |-> o_timeout_flag)
    else $error("watchdog wake without time-out flag");
  a_wdt_wake_len: assert property (o_wdt_reset |-> cnt_q == RESTART_CYCLES)
    else $error("watchdog reset not at end of delay");
  a_int_gap: assert property (o_int_service |-> cnt_q > RESTART_CYCLES)
    else $error("interrupt entry too early");
endmodule // pmw_ctrl_chk
bind pmw_ctrl pmw_ctrl_chk #(.RESTART_CYCLES(RESTART_CYCLES)) u_chk (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_stop_exec(i_stop_exec),
  .i_watchdog_clear_instruction(i_watchdog_clear_instruction),
  .i_lcd_clock_enable(i_lcd_clock_enable), .i_wdt_option_en(i_wdt_option_en),
  .i_wdt_ctrl_en(i_wdt_ctrl_en), .o_main_clk_en(o_main_clk_en), .o_sys_tick(o_sys_tick),
  .o_int_clk_en(o_int_clk_en), .o_lcd_clk_en(o_lcd_clk_en), .o_wdt_clk_en(o_wdt_clk_en),
  .o_cpu_run(o_cpu_run), .o_wdt_clear(o_wdt_clear), .o_wdt_reset(o_wdt_reset),
  .o_resume_next(o_resume_next), .o_int_service(o_int_service), .o_mode(o_mode),
  .o_powerdown_flag(o_powerdown_flag), .o_timeout_flag(o_timeout_flag));
`default_nettype wire

// >>> verif/pmw_wake_model.sv
// Purpose: wake sources beside the controller
// Assumes: strobes arrive one cycle wide
// Notes: pins idle high as if pulled up
`timescale 1ns/1ns
`default_nettype none
module pmw_wake_model (
  // Clock and commands
  input wire logic i_mclk,
  input wire logic [3:0] i_go,
  input wire logic [2:0] i_pin,
  input wire logic i_int_lvl,
  // Wake lines
  output logic [7:0] o_porta,
  output logic o_int_req,
  output logic o_ext_reset_n,
  output logic o_wdt_overflow
);
  logic [2:0] cnt_q = 3'h0;
  logic [3:0] kind_q = 4'h0;
  logic [2:0] pin_q = 3'h0;
  logic act;
  // Hold each event four cycles, longer than the pin synchroniser needs
  always_ff @(posedge i_mclk) begin
    if (i_go != 4'h0) begin
      kind_q <= i_go;
      pin_q <= i_pin;
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  // Falling pin, rising request, low reset pin, high overflow
  assign act = cnt_q != 3'h0;
  assign o_porta = ~((act && kind_q[0]) ? (8'h01 << pin_q) : 8'h00);
  assign o_int_req = i_int_lvl | (act && kind_q[1]);
  assign o_ext_reset_n = !(act && kind_q[2]);
  assign o_wdt_overflow = act && kind_q[3];
endmodule // pmw_wake_model
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the power mode controller
// Assumes: restart shortened to 8 ticks
// Notes: mode table first, awkward wakes after
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // Row: speed select, lcd enable, idle select, pin, mode running, mode down
  typedef struct packed {
    logic s;
    logic l;
    logic d;
    logic [2:0] p;
    logic [1:0] mr;
    logic [1:0] md;
  } pmw_row_t;
  pmw_row_t rows [4] = '{'{1'b1, 1'b1, 1'b1, 3'h0, 2'h0, 2'h2},
    '{1'b1, 1'b0, 1'b0, 3'h3, 2'h0, 2'h3},
    '{1'b0, 1'b1, 1'b1, 3'h5, 2'h1, 2'h2}, '{1'b0, 1'b0, 1'b0, 3'h7, 2'h1, 2'h3}};
  logic i_mclk, i_nrst, spd, idl, lcd, wopt, wctl, wsub, stop, clr, ien, stk, ilvl, seen;
  logic [2:0] div, pin;
  logic [7:0] wen, porta, cnt;
  logic [3:0] go;
  logic intr, extn, wovf, men, sen, tick, suben, icen, lcd_gate, wden;
  logic run, wclr, frst, wrst, rnext, isvc, pwdn, tof;
  logic [1:0] mode;
  int n_fail, tests_run;
  pmw_wake_model u_wake (.i_mclk(i_mclk), .i_go(go), .i_pin(pin), .i_int_lvl(ilvl),
    .o_porta(porta), .o_int_req(intr), .o_ext_reset_n(extn), .o_wdt_overflow(wovf));
  pmw_ctrl #(.RESTART_CYCLES(8)) DUT (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_clock_speed_select(spd), .i_idle_select(idl), .i_slow_clock_divider(div),
    .i_lcd_clock_enable(lcd), .i_wdt_option_en(wopt), .i_wdt_ctrl_en(wctl),
    .i_wdt_src_sub(wsub), .i_wdt_overflow(wovf), .i_stop_exec(stop),
    .i_watchdog_clear_instruction(clr), .i_ext_reset_n(extn), .i_porta(porta),
    .i_porta_wake_en(wen), .i_int_req(intr), .i_int_enabled(ien), .i_stack_full(stk),
    .o_main_clk_en(men), .o_slow_clk_en(sen), .o_sys_tick(tick), .o_sub_clk_en(suben),
    .o_int_clk_en(icen), .o_lcd_clk_en(lcd_gate), .o_wdt_clk_en(wden), .o_cpu_run(run),
    .o_wdt_clear(wclr), .o_full_reset(frst), .o_wdt_reset(wrst), .o_resume_next(rnext),
    .o_int_service(isvc), .o_mode(mode), .o_powerdown_flag(pwdn), .o_timeout_flag(tof));
  // Clock and watchdog
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chkv(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic halt();
    @(posedge i_mclk);
    stop <= 1'b1;
    @(posedge i_mclk);
    stop <= 1'b0;
    #1;
  endtask
  task automatic wake(input logic [3:0] k, input logic [2:0] p);
    @(posedge i_mclk);
    go <= k;
    pin <= p;
    @(posedge i_mclk);
    go <= 4'h0;
  endtask
  // Bounded wait for one completion pulse: 0 resume, 1 full, 2 watchdog, 3 service
  task automatic waitp(input int k, input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && seen !== 1'b1; i++) begin
      @(posedge i_mclk);
      #1;
      seen = k == 0 ? rnext : k == 1 ? frst : k == 2 ? wrst : isvc;
    end
  endtask
  task automatic ticks(input logic [2:0] c, input int n, input logic [7:0] e);
    @(posedge i_mclk);
    div <= c;
    repeat (3) @(posedge i_mclk);
    cnt = 8'h0;
    repeat (n) begin
      @(posedge i_mclk);
      #1;
      cnt = cnt + {7'h0, tick};
    end
    chkv("slow_ticks", e, cnt);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    {spd, idl, lcd, wopt, wctl, wsub, stop, clr, ien, stk, ilvl} <= 11'h5e0;
    {i_nrst, div, pin, wen, go} <= {1'b0, 3'h0, 3'h0, 8'hff, 4'h0};
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    #1;
    chk1("pwdn_reset", 1'b0, pwdn);
    chk1("sub_clk", 1'b1, suben);
    $display("reset test done");
    foreach (rows[r]) begin
      @(posedge i_mclk);
      {spd, lcd, idl} <= {rows[r].s, rows[r].l, rows[r].d};
      repeat (2) @(posedge i_mclk);
      #1;
      chkv("mode_run", {6'h0, rows[r].mr}, {6'h0, mode});
      halt();
      chkv("mode_down", {6'h0, rows[r].md}, {6'h0, mode});
      chk1("run_down", 1'b0, run);
      chk1("pwdn_set", 1'b1, pwdn);
      chk1("main_down", 1'b0, men);
      chk1("slow_down", 1'b0, sen);
      chk1("int_clk_down", rows[r].d, icen);
      chk1("lcd_down", rows[r].l && rows[r].d, lcd_gate);
      wake(4'h1, rows[r].p);
      waitp(0, 700);
      chk1("resume", 1'b1, seen);
      $display("row %0d done", r);
    end
    // Masked pin, stale interrupt, serviced and unserviced interrupts
    // Request raised well before stop so the synchroniser has settled
    @(posedge i_mclk);
    {spd, wen, ilvl} <= {1'b1, 8'hfe, 1'b1};
    repeat (4) @(posedge i_mclk);
    halt();
    // Drop it so the stale request can make a fresh edge while down
    @(posedge i_mclk);
    ilvl <= 1'b0;
    wake(4'h1, 3'h0);
    waitp(0, 40);
    chk1("masked_pin", 1'b0, seen);
    wake(4'h2, 3'h0);
    waitp(0, 40);
    chk1("stale_int", 1'b0, seen);
    wake(4'h1, 3'h1);
    waitp(0, 60);
    chk1("pin1_wake", 1'b1, seen);
    @(posedge i_mclk);
    ien <= 1'b1;
    halt();
    wake(4'h2, 3'h0);
    waitp(3, 60);
    chk1("int_service", 1'b1, seen);
    @(posedge i_mclk);
    stk <= 1'b1;
    halt();
    wake(4'h2, 3'h0);
    waitp(0, 60);
    chk1("int_stack_full", 1'b1, seen);
    $display("wake source tests done");
    halt();
    wake(4'h8, 3'h0);
    waitp(2, 60);
    chk1("wdt_wake", 1'b1, seen);
    chk1("to_set", 1'b1, tof);
    chk1("pwdn_kept", 1'b1, pwdn);
    @(posedge i_mclk);
    clr <= 1'b1;
    @(posedge i_mclk);
    clr <= 1'b0;
    #1;
    chk1("pwdn_clr", 1'b0, pwdn);
    @(posedge i_mclk);
    wsub <= 1'b0;
    halt();
    chk1("to_clr", 1'b0, tof);
    chk1("wdt_clr", 1'b1, wclr);
    chk1("wdt_sys_stop", 1'b0, wden);
    wake(4'h4, 3'h0);
    waitp(1, 60);
    chk1("reset_wake", 1'b1, seen);
    repeat (40) @(posedge i_mclk);
    {spd, wopt} <= 2'h0;
    ticks(3'h2, 64, 8'h08);
    ticks(3'h7, 128, 8'h02);
    chk1("wdt_opt_off", 1'b0, wden);
    $display("watchdog and slow tests done");
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
